// ===== shared/synth_ctrl_cfg.svh
// constants of the tuner synthesizer control register bank
// assumes a two-wire serial host and one register clock
//
// Summary of operation
// - start-source bit 0 starts autoselect from register band/sub-band, 1 from current.
// - autoselect enable runs the state machine; when clear, manual band fields rule.
// - pump-auto bit selects automatic pump current; host also sets enable/adc bits.
// - adc latch bit set latches the tuning converter value; clear disables latching.
// - adc enable bit set enables reading the tuning converter; clear disables it.
// - two-bit wait field selects 14336, 24576, 34816 or 45056 crystal periods.
// - band field codes 00/01/10 activate oscillator 0/1/2; 11 is unused.
// - four-bit sub-band field picks one of sixteen sub-bands; also autoselect start.
// - bias bit 0 gives normal oscillator bias, 1 gives low-power bias.
// - detector mode 00 closed loop buffer off, 01 rms open loop, 11 echo.
// - attack point field steps 2 dB from -66 dBm at 000 to -52 dBm.
// - tracking filter field sets centre frequency; code 000 is the minimum.
// - stage-3 bypass bit set disables the third rf gain stage.
// - filter bypass bit set disables the integrated rf filter.
// - injection bit 1 selects low-side, 0 selects high-side lo injection.
// - device answers on the serial bus at write address c0, read c1.
`ifndef SYNTH_CTRL_CFG_SVH
`define SYNTH_CTRL_CFG_SVH

`define DEV_WR_ADDR   8'hc0
`define DEV_RD_ADDR   8'hc1

`define OFS_AUTOSEL   8'h01
`define OFS_BAND      8'h02
`define OFS_DETECT    8'h03
`define OFS_MODE      8'h04
`define BANK_DEPTH    4

`define RST_AUTOSEL   8'hb3
`define RST_BAND      8'h29
`define RST_DETECT    8'h23
`define RST_MODE      8'h00

`define B_START_SRC   6
`define B_AUTO_EN     5
`define B_PUMP_AUTO   4
`define B_ADC_LATCH   3
`define B_ADC_EN      2
`define B_WAIT_LSB    0
`define B_BAND_LSB    5
`define B_SUB_LSB     1
`define B_BIAS        0
`define B_BUF_LSB     6
`define B_ATK_LSB     3
`define B_TRK_LSB     0
`define B_STAGE3      7
`define B_FILTER      6
`define B_INJECT      5

`define WAIT_00       16'h3800
`define WAIT_01       16'h6000
`define WAIT_10       16'h8800
`define WAIT_11       16'hb000

`define ATK_BASE_DBM  7'h42
`define ATK_LAST_DBM  7'h34

`endif

// ===== shared/synth_ctrl_pkg.sv
// types of the tuner synthesizer control register bank
// assumes synth_ctrl_cfg.svh for all numeric constants
package synth_ctrl_pkg;

	typedef enum logic [2:0] {
		st_idle  = 3'b000,
		st_addr  = 3'b001,
		st_ack   = 3'b010,
		st_ptr   = 3'b011,
		st_wr    = 3'b100,
		st_rd    = 3'b101,
		st_rack  = 3'b110,
		st_rload = 3'b111
	} bus_state_t;

	typedef struct packed {
		logic        start_from_current;
		logic        autoselect_on;
		logic        manual_band;
		logic        pump_auto;
		logic        adc_latch;
		logic        adc_read;
		logic [15:0] wait_periods;
		logic [1:0]  band_code;
		logic [2:0]  osc_onehot;
		logic [3:0]  subband;
		logic        low_power_bias;
		logic        det_buffer_on;
		logic        rms_to_pin;
		logic        gc_echo;
		logic        closed_loop;
		logic [6:0]  attack_neg_dbm;
		logic [2:0]  filter_tune;
		logic        stage3_on;
		logic        filter_on;
		logic        low_side;
	} synth_ctrl_t;

endpackage : synth_ctrl_pkg

// ===== core/ctrl_byte_bank.sv
// four control bytes with power-up defaults and a registered read port
// assumes the caller decodes the address range
`timescale 1ns/1ps
`include "synth_ctrl_cfg.svh"
module ctrl_byte_bank (
	input  wire logic                        mclk_in,
	input  wire logic                        reset_in,
	input  wire logic                        wr_en_in,
	input  wire logic [1:0]                  wr_idx_in,
	input  wire logic [7:0]                  wr_data_in,
	input  wire logic                        rd_map_in,
	input  wire logic [1:0]                  rd_idx_in,
	output logic      [7:0]                  rd_data_out,
	output logic      [`BANK_DEPTH-1:0][7:0] regs_out
);
	localparam logic [`BANK_DEPTH-1:0][7:0] RST_VAL =
		{`RST_MODE, `RST_DETECT, `RST_BAND, `RST_AUTOSEL};

	logic [7:0] rd_nxt;

	////////////////////////////////////////////////////////////////
	genvar gi;
	generate
		for (gi = 0; gi < `BANK_DEPTH; gi++) begin : g_byte
			logic [7:0] byte_nxt;
			always_comb begin
				byte_nxt = regs_out[gi];
				if (wr_en_in && wr_idx_in == 2'(gi))
					byte_nxt = wr_data_in;
			end
			always_ff @(posedge mclk_in) begin
				if (reset_in)
					regs_out[gi] <= RST_VAL[gi];
				else
					regs_out[gi] <= byte_nxt;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	always_comb begin
		rd_nxt = rd_map_in ? regs_out[rd_idx_in] : 8'h00;
	end

	always_ff @(posedge mclk_in) begin
		if (reset_in)
			rd_data_out <= 8'h00;
		else
			rd_data_out <= rd_nxt;
	end

endmodule : ctrl_byte_bank

// ===== core/tuner_synth_control_regs.sv
// two-wire serial slave holding the synthesizer control bytes
// assumes scl and sda arrive from pins; sda is open drain, pulled up outside
`timescale 1ns/1ps
`include "synth_ctrl_cfg.svh"
module tuner_synth_control_regs (
	input  wire logic                        mclk_in,
	input  wire logic                        reset_in,
	input  wire logic                        scl_in,
	input  wire logic                        sda_in,
	output logic                             sda_out,
	output logic                             sda_oe_out,
	output synth_ctrl_pkg::synth_ctrl_t      ctrl_out
);
	import synth_ctrl_pkg::*;

	logic                        scl_s1_r, scl_s2_r, scl_d_r;
	logic                        sda_s1_r, sda_s2_r, sda_d_r;
	logic                        scl_rise, scl_fall, bus_start, bus_stop;
	bus_state_t                  st_r, st_nxt;
	logic [3:0]                  cnt_r, cnt_nxt;
	logic [7:0]                  sh_r, sh_nxt;
	logic [7:0]                  tx_r, tx_nxt;
	logic [7:0]                  ptr_r, ptr_nxt;
	logic [1:0]                  kind_r, kind_nxt;
	logic                        rw_r, rw_nxt;
	logic                        ackon_r, ackon_nxt;
	logic                        oe_r, oe_nxt;
	logic                        wr_en_r, wr_en_nxt;
	logic [7:0]                  wr_byte_r, wr_byte_nxt;
	logic [1:0]                  wr_idx_r, wr_idx_nxt;
	logic [7:0]                  byte_in;
	logic                        ptr_map;
	logic [1:0]                  ptr_idx;
	logic [7:0]                  rd_byte;
	logic [`BANK_DEPTH-1:0][7:0] regs;
	synth_ctrl_t                 ctrl_r, ctrl_nxt;

	////////////////////////////////////////////////////////////////
	// pin synchronisers and bus events
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			scl_d_r  <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
			sda_d_r  <= 1'b1;
		end else begin
			scl_s1_r <= scl_in;
			scl_s2_r <= scl_s1_r;
			scl_d_r  <= scl_s2_r;
			sda_s1_r <= sda_in;
			sda_s2_r <= sda_s1_r;
			sda_d_r  <= sda_s2_r;
		end
	end

	assign scl_rise  = scl_s2_r & ~scl_d_r;
	assign scl_fall  = ~scl_s2_r & scl_d_r;
	assign bus_start = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
	assign bus_stop  = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
	assign byte_in   = {sh_r[6:0], sda_s2_r};
	assign ptr_map   = (ptr_r >= `OFS_AUTOSEL) && (ptr_r <= `OFS_MODE);
	assign ptr_idx   = 2'(ptr_r - `OFS_AUTOSEL);

	////////////////////////////////////////////////////////////////
	// serial protocol engine
	always_comb begin
		st_nxt      = st_r;
		cnt_nxt     = cnt_r;
		sh_nxt      = sh_r;
		tx_nxt      = tx_r;
		ptr_nxt     = ptr_r;
		kind_nxt    = kind_r;
		rw_nxt      = rw_r;
		ackon_nxt   = ackon_r;
		oe_nxt      = oe_r;
		wr_en_nxt   = 1'b0;
		wr_byte_nxt = wr_byte_r;
		wr_idx_nxt  = wr_idx_r;
		if (bus_start) begin
			st_nxt    = st_addr;
			cnt_nxt   = 4'h0;
			oe_nxt    = 1'b0;
			ackon_nxt = 1'b0;
		end else if (bus_stop) begin
			st_nxt    = st_idle;
			oe_nxt    = 1'b0;
			ackon_nxt = 1'b0;
		end else begin
			unique case (st_r)
				st_idle: begin
				end
				st_addr, st_ptr, st_wr: begin
					if (scl_rise) begin
						sh_nxt  = byte_in;
						cnt_nxt = cnt_r + 4'h1;
						if (cnt_r == 4'h7) begin
							cnt_nxt = 4'h0;
							st_nxt  = st_ack;
							if (st_r == st_addr) begin
								kind_nxt = 2'h0;
								rw_nxt   = byte_in[0];
								if (byte_in[7:1] != 7'(`DEV_WR_ADDR >> 1))
									st_nxt = st_idle;
							end else if (st_r == st_ptr) begin
								kind_nxt = 2'h1;
								ptr_nxt  = byte_in;
							end else begin
								kind_nxt    = 2'h2;
								wr_en_nxt   = ptr_map;
								wr_byte_nxt = byte_in;
								wr_idx_nxt  = ptr_idx;
							end
						end
					end
				end
				st_ack: begin
					if (scl_fall) begin
						if (!ackon_r) begin
							ackon_nxt = 1'b1;
							oe_nxt    = 1'b1;
						end else begin
							ackon_nxt = 1'b0;
							oe_nxt    = 1'b0;
							if (kind_r == 2'h0 && rw_r) begin
								tx_nxt = rd_byte;
								oe_nxt = ~rd_byte[7];
								st_nxt = st_rd;
							end else if (kind_r == 2'h0) begin
								st_nxt = st_ptr;
							end else begin
								if (kind_r == 2'h2)
									ptr_nxt = ptr_r + 8'h01;
								st_nxt = st_wr;
							end
						end
					end
				end
				st_rd: begin
					if (scl_rise)
						cnt_nxt = cnt_r + 4'h1;
					if (scl_fall) begin
						if (cnt_r == 4'h8) begin
							oe_nxt = 1'b0;
							st_nxt = st_rack;
						end else begin
							tx_nxt = {tx_r[6:0], 1'b0};
							oe_nxt = ~tx_r[6];
						end
					end
				end
				st_rack: begin
					if (scl_rise) begin
						if (sda_s2_r) begin
							st_nxt = st_idle;
						end else begin
							ptr_nxt = ptr_r + 8'h01;
							st_nxt  = st_rload;
						end
					end
				end
				st_rload: begin
					if (scl_fall) begin
						tx_nxt  = rd_byte;
						oe_nxt  = ~rd_byte[7];
						cnt_nxt = 4'h0;
						st_nxt  = st_rd;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			st_r      <= st_idle;
			cnt_r     <= 4'h0;
			sh_r      <= 8'h00;
			tx_r      <= 8'h00;
			ptr_r     <= 8'h00;
			kind_r    <= 2'h0;
			rw_r      <= 1'b0;
			ackon_r   <= 1'b0;
			oe_r      <= 1'b0;
			wr_en_r   <= 1'b0;
			wr_byte_r <= 8'h00;
			wr_idx_r  <= 2'h0;
		end else begin
			st_r      <= st_nxt;
			cnt_r     <= cnt_nxt;
			sh_r      <= sh_nxt;
			tx_r      <= tx_nxt;
			ptr_r     <= ptr_nxt;
			kind_r    <= kind_nxt;
			rw_r      <= rw_nxt;
			ackon_r   <= ackon_nxt;
			oe_r      <= oe_nxt;
			wr_en_r   <= wr_en_nxt;
			wr_byte_r <= wr_byte_nxt;
			wr_idx_r  <= wr_idx_nxt;
		end
	end

	assign sda_out    = 1'b0;
	assign sda_oe_out = oe_r;

	////////////////////////////////////////////////////////////////
	ctrl_byte_bank u_bank (
		.mclk_in     (mclk_in),
		.reset_in    (reset_in),
		.wr_en_in    (wr_en_r),
		.wr_idx_in   (wr_idx_r),
		.wr_data_in  (wr_byte_r),
		.rd_map_in   (ptr_map),
		.rd_idx_in   (ptr_idx),
		.rd_data_out (rd_byte),
		.regs_out    (regs)
	);

	////////////////////////////////////////////////////////////////
	// field decode
	always_comb begin
		ctrl_nxt = '0;
		ctrl_nxt.start_from_current = regs[0][`B_START_SRC];
		ctrl_nxt.autoselect_on      = regs[0][`B_AUTO_EN];
		ctrl_nxt.manual_band        = ~regs[0][`B_AUTO_EN];
		ctrl_nxt.pump_auto          = regs[0][`B_PUMP_AUTO];
		ctrl_nxt.adc_latch          = regs[0][`B_ADC_LATCH];
		ctrl_nxt.adc_read           = regs[0][`B_ADC_EN];
		unique case (regs[0][`B_WAIT_LSB +: 2])
			2'b00: ctrl_nxt.wait_periods = `WAIT_00;
			2'b01: ctrl_nxt.wait_periods = `WAIT_01;
			2'b10: ctrl_nxt.wait_periods = `WAIT_10;
			2'b11: ctrl_nxt.wait_periods = `WAIT_11;
		endcase
		ctrl_nxt.band_code = regs[1][`B_BAND_LSB +: 2];
		unique case (regs[1][`B_BAND_LSB +: 2])
			2'b00: ctrl_nxt.osc_onehot = 3'b001;
			2'b01: ctrl_nxt.osc_onehot = 3'b010;
			2'b10: ctrl_nxt.osc_onehot = 3'b100;
			2'b11: ctrl_nxt.osc_onehot = 3'b000;
		endcase
		ctrl_nxt.subband        = regs[1][`B_SUB_LSB +: 4];
		ctrl_nxt.low_power_bias = regs[1][`B_BIAS];
		unique case (regs[2][`B_BUF_LSB +: 2])
			2'b00: ctrl_nxt.closed_loop = 1'b1;
			2'b01: begin
				ctrl_nxt.det_buffer_on = 1'b1;
				ctrl_nxt.rms_to_pin    = 1'b1;
			end
			2'b10: ctrl_nxt.closed_loop = 1'b1;
			2'b11: begin
				ctrl_nxt.det_buffer_on = 1'b1;
				ctrl_nxt.gc_echo       = 1'b1;
				ctrl_nxt.closed_loop   = 1'b1;
			end
		endcase
		ctrl_nxt.attack_neg_dbm = `ATK_BASE_DBM - {3'h0, regs[2][`B_ATK_LSB +: 3], 1'b0};
		ctrl_nxt.filter_tune    = regs[2][`B_TRK_LSB +: 3];
		ctrl_nxt.stage3_on      = ~regs[3][`B_STAGE3];
		ctrl_nxt.filter_on      = ~regs[3][`B_FILTER];
		ctrl_nxt.low_side       = regs[3][`B_INJECT];
	end

	always_ff @(posedge mclk_in) begin
		if (reset_in)
			ctrl_r <= '0;
		else
			ctrl_r <= ctrl_nxt;
	end

	assign ctrl_out = ctrl_r;

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (reset_in);

	a_addr_match: assert property (
		st_r == st_addr && !bus_start && !bus_stop && scl_rise && cnt_r == 4'h7
		&& byte_in[7:1] == 7'(`DEV_RD_ADDR >> 1) |=> st_r == st_ack && rw_r == $past(byte_in[0]))
		else $error("own address not acknowledged");
	a_addr_foreign: assert property (
		st_r == st_addr && !bus_start && !bus_stop && scl_rise && cnt_r == 4'h7
		&& byte_in[7:1] != 7'(`DEV_WR_ADDR >> 1) |=> st_r == st_idle)
		else $error("foreign address accepted");
	a_write_store: assert property (
		wr_en_r |-> ##1 regs[$past(wr_idx_r)] == $past(wr_byte_r))
		else $error("written byte not stored");
	a_read_back: assert property (
		ptr_map && !wr_en_r |=> rd_byte == $past(regs[ptr_idx]))
		else $error("read data differs from stored byte");
	a_wait_long: assert property (
		regs[0][1:0] == 2'b11 |=> ctrl_r.wait_periods == 16'hb000)
		else $error("wait count wrong for code 11");
	a_wait_short: assert property (
		regs[0][1:0] == 2'b00 |=> ctrl_r.wait_periods == 16'h3800)
		else $error("wait count wrong for code 00");
	a_band_unused: assert property (
		regs[1][6:5] == 2'b11 |=> ctrl_r.osc_onehot == 3'b000)
		else $error("unused band code activates an oscillator");
	a_attack_top: assert property (
		regs[2][5:3] == 3'b111 |=> ctrl_r.attack_neg_dbm == `ATK_LAST_DBM)
		else $error("attack point wrong at top code");
	a_buffer_off: assert property (
		regs[2][7:6] == 2'b00 |=> !ctrl_r.det_buffer_on && ctrl_r.closed_loop)
		else $error("buffer mode 00 decoded wrongly");
	a_stage3_bypass: assert property (
		wr_en_r && wr_idx_r == 2'h3 |-> ##2 ctrl_r.stage3_on == !$past(wr_byte_r[7], 2))
		else $error("stage three bypass not applied");

endmodule : tuner_synth_control_regs

// ===== dv/serial_host_model.sv
// two-wire serial host model for the control bank
// assumes the bench resolves the open-drain data line with a pull-up
`timescale 1ns/1ps
module serial_host_model (
	input  wire logic mclk_in,
	input  wire logic sda_line_in,
	output logic      scl_out,
	output logic      sda_low_out
);
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	task automatic wait_clk(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask : wait_clk

	// scl high for 8 clocks and low for 10, data moved 2 clocks after scl falls
	task automatic bit_xfer(input logic b, output logic seen);
		wait_clk(2);
		sda_low_out = ~b;
		wait_clk(8);
		scl_out = 1'b1;
		wait_clk(8);
		seen = sda_line_in;
		scl_out = 1'b0;
	endtask : bit_xfer

	task automatic bus_start();
		if (!scl_out) begin
			wait_clk(2);
			sda_low_out = 1'b0;
			wait_clk(8);
			scl_out = 1'b1;
		end
		wait_clk(8);
		sda_low_out = 1'b1;
		wait_clk(8);
		scl_out = 1'b0;
	endtask : bus_start

	task automatic bus_stop();
		wait_clk(2);
		sda_low_out = 1'b1;
		wait_clk(8);
		scl_out = 1'b1;
		wait_clk(8);
		sda_low_out = 1'b0;
		wait_clk(8);
	endtask : bus_stop

	task automatic byte_out(input logic [7:0] b, inout logic ok);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(b[i], s);
		end
		bit_xfer(1'b1, s);
		ok = ok & ~s;
	endtask : byte_out

	task automatic byte_in(input logic last, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(1'b1, s);
			b[i] = s;
		end
		bit_xfer(last, s);
	endtask : byte_in
	////////////////////////////////////////////////////////////////
	task automatic write_seq(input logic [7:0] dev, input logic [7:0] ptr,
		input logic [7:0] d [4], input int n, output logic ok);
		ok = 1'b1;
		bus_start();
		byte_out(dev, ok);
		byte_out(ptr, ok);
		for (int i = 0; i < n; i++) begin
			byte_out(d[i], ok);
		end
		bus_stop();
	endtask : write_seq

	task automatic read_seq(input logic [7:0] ptr, input int n,
		output logic [7:0] d [4], output logic ok);
		ok = 1'b1;
		bus_start();
		byte_out(8'hc0, ok);
		byte_out(ptr, ok);
		bus_start();
		byte_out(8'hc1, ok);
		for (int i = 0; i < n; i++) begin
			byte_in(i == n - 1, d[i]);
		end
		bus_stop();
	endtask : read_seq
endmodule : serial_host_model

// ===== dv/tuner_synth_control_regs_tb.sv
// self-checking bench for the synthesizer control bank
// assumes serial_host_model and a pulled-up data line
`timescale 1ns/1ps
module tuner_synth_control_regs_tb;
	import synth_ctrl_pkg::*;
	typedef struct packed {
		logic [7:0] ptr;
		logic [7:0] data;
	} row_t;
	logic        mclk;
	logic        rst;
	logic        scl;
	logic        host_low;
	logic        dev_sda;
	logic        dev_oe;
	wire         sda_line;
	synth_ctrl_t ctrl_out;
	int          mismatches;
	int          cmp_count;
	logic        ok;
	logic [7:0]  shadow [4];
	logic [7:0]  rd [4];
	logic [7:0]  wr [4];
	// reserved bits held at fixed values
	row_t        rows [16] = '{
		'{8'h01, 8'hfc}, '{8'h01, 8'h81}, '{8'h01, 8'hc2}, '{8'h01, 8'ha3},
		'{8'h02, 8'h00}, '{8'h02, 8'h3f}, '{8'h02, 8'h48}, '{8'h02, 8'h61},
		'{8'h03, 8'h00}, '{8'h03, 8'h7f}, '{8'h03, 8'h95}, '{8'h03, 8'hc0},
		'{8'h04, 8'he0}, '{8'h04, 8'h40}, '{8'h04, 8'h20}, '{8'h04, 8'h80}};

	assign sda_line = !(host_low || (dev_oe && !dev_sda));
	always #2.5 mclk = ~mclk;

	tuner_synth_control_regs uut (
		.mclk_in(mclk), .reset_in(rst), .scl_in(scl), .sda_in(sda_line),
		.sda_out(dev_sda), .sda_oe_out(dev_oe), .ctrl_out(ctrl_out));
	serial_host_model host (
		.mclk_in(mclk), .sda_line_in(sda_line), .scl_out(scl), .sda_low_out(host_low));
	////////////////////////////////////////////////////////////////
	function automatic synth_ctrl_t expect_ctrl(input logic [7:0] a, b, d, m);
		synth_ctrl_t e;
		e = '0;
		e.start_from_current = a[6];
		e.autoselect_on = a[5];
		e.manual_band = ~a[5];
		e.pump_auto = a[4];
		e.adc_latch = a[3];
		e.adc_read = a[2];
		case (a[1:0])
			2'h0: e.wait_periods = 16'h3800;
			2'h1: e.wait_periods = 16'h6000;
			2'h2: e.wait_periods = 16'h8800;
			default: e.wait_periods = 16'hb000;
		endcase
		e.band_code = b[6:5];
		e.osc_onehot = (b[6:5] == 2'h3) ? 3'h0 : 3'(3'h1 << b[6:5]);
		e.subband = b[4:1];
		e.low_power_bias = b[0];
		e.det_buffer_on = d[6];
		e.rms_to_pin = (d[7:6] == 2'h1);
		e.gc_echo = (d[7:6] == 2'h3);
		e.closed_loop = (d[7:6] != 2'h1);
		e.attack_neg_dbm = 7'h42 - {3'h0, d[5:3], 1'b0};
		e.filter_tune = d[2:0];
		e.stage3_on = ~m[7];
		e.filter_on = ~m[6];
		e.low_side = m[5];
		return e;
	endfunction : expect_ctrl

	task automatic check(input logic [63:0] seen, exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic check_ctrl(input string what);
		synth_ctrl_t e;
		e = expect_ctrl(shadow[0], shadow[1], shadow[2], shadow[3]);
		check(64'(ctrl_out), 64'(e), what);
	endtask : check_ctrl

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : final_report
	////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		repeat (8) @(posedge mclk);
		#1;
		check(64'(dev_oe), 64'h0, "oe in reset");
		check(64'(ctrl_out), 64'h0, "ctrl in reset");
		rst = 1'b0;
		@(posedge mclk);
		#1;
		shadow = '{8'hb3, 8'h29, 8'h23, 8'h00};
		check_ctrl("power-up defaults");
		$display("reset test done");
		// host idle 100 us before writing
		repeat (20000) @(posedge mclk);
		foreach (rows[i]) begin
			wr[0] = rows[i].data;
			host.write_seq(8'hc0, rows[i].ptr, wr, 1, ok);
			check(64'(ok), 64'h1, "write ack");
			shadow[2'(rows[i].ptr - 8'h1)] = rows[i].data;
			check_ctrl("row decode");
			host.read_seq(rows[i].ptr, 1, rd, ok);
			check(64'(ok), 64'h1, "read ack");
			check(64'(rd[0]), 64'(rows[i].data), "row readback");
			$display("row %0d done", i);
		end
		wr = '{8'h87, 8'h5e, 8'h6b, 8'hc0};
		host.write_seq(8'hc0, 8'h01, wr, 4, ok);
		shadow = wr;
		check(64'(ok), 64'h1, "burst ack");
		check_ctrl("burst decode");
		host.read_seq(8'h01, 4, rd, ok);
		for (int i = 0; i < 4; i++) begin
			check(64'(rd[i]), 64'(wr[i]), "burst readback");
		end
		$display("burst test done");
		wr[0] = 8'h5a;
		host.write_seq(8'hc0, 8'h05, wr, 1, ok);
		host.write_seq(8'hc0, 8'h00, wr, 1, ok);
		check_ctrl("unmapped write");
		host.read_seq(8'h05, 1, rd, ok);
		check(64'(rd[0]), 64'h0, "unmapped read");
		wr[0] = 8'h00;
		host.write_seq(8'ha0, 8'h04, wr, 1, ok);
		check(64'(ok), 64'h0, "foreign nack");
		check_ctrl("foreign ignored");
		$display("refusal test done");
		rst = 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		rst = 1'b0;
		@(posedge mclk);
		#1;
		shadow = '{8'hb3, 8'h29, 8'h23, 8'h00};
		check_ctrl("second reset defaults");
		$display("second reset test done");
		final_report();
	end

	initial begin
		repeat (90000) @(posedge mclk);
		mismatches++;
		$display("Error at %0t ns: run timed out", $time);
		final_report();
	end
endmodule : tuner_synth_control_regs_tb
